// file: hdl/dlr_pkg.sv
// Constants shared by the dead-line close-release logic
package dlr_pkg;
	localparam int NUM_GROUPS   = 4;
	localparam int GRP_W        = 2;
	localparam int NUM_COND     = 3;
	localparam int COND_LD      = 0;  // Live reference, dead other
	localparam int COND_DL      = 1;  // Dead reference, live other
	localparam int COND_DD      = 2;  // Both dead
	localparam int NUM_PHASES   = 3;
	localparam int PHASE_SINGLE = 0;  // Phase checked for dead on a single-phase connection
	localparam int CLK_MHZ      = 100;
	localparam int HOLD_TIME_US = 100000;
	localparam int HOLD_CYCLES  = HOLD_TIME_US * CLK_MHZ;
	localparam int HOLD_CNT_W   = 24;

	typedef enum logic {
		DLR_IDLE,
		DLR_MEAS
	} dlr_state_t;
endpackage : dlr_pkg

// file: hdl/dlr_hold_if.sv
// Condition and supervision-hold signals between controller and hold timer
`timescale 1ns/1ns
interface dlr_hold_if #(
	parameter int NCOND = dlr_pkg::NUM_COND
);
	logic             clear;
	logic [NCOND-1:0] cond;
	logic [NCOND-1:0] held;

	modport ctrl (output clear, output cond, input held);
	modport timer (input clear, input cond, output held);
endinterface : dlr_hold_if

// file: hdl/dlr_hold_timer.sv
// Per-condition supervision timers for dead-side release
`timescale 1ns/1ns
module dlr_hold_timer #(
	parameter int NCOND       = dlr_pkg::NUM_COND,
	parameter int CNT_W       = dlr_pkg::HOLD_CNT_W,
	parameter int HOLD_CYCLES = dlr_pkg::HOLD_CYCLES
) (
	input  wire logic clk_sys,
	input  wire logic reset_n,
	dlr_hold_if.timer hif
);
	localparam logic [CNT_W-1:0] HOLD_LIM = CNT_W'(HOLD_CYCLES);

	// Counter must reach the limit without wrapping
	if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (2 ** CNT_W) || NCOND < 1) begin : g_bad_hold
		$error("dlr_hold_timer: HOLD_CYCLES does not fit the counter");
	end

	genvar gi;
	generate
		for (gi = 0; gi < NCOND; gi++) begin : g_cond
			logic [CNT_W-1:0] cnt_r;
			logic [CNT_W-1:0] cnt_nxt;

			// Count continuous presence; any dropout restarts the wait
			always_comb begin
				cnt_nxt = cnt_r;
				if (hif.clear || !hif.cond[gi])
					cnt_nxt = '0;
				else if (cnt_r != HOLD_LIM)
					cnt_nxt = cnt_r + CNT_W'(1);
			end

			always_ff @(posedge clk_sys) begin
				if (!reset_n)
					cnt_r <= '0;
				else
					cnt_r <= cnt_nxt;
			end

			// Gated by the live condition so a dropout releases at once
			assign hif.held[gi] = hif.cond[gi] && !hif.clear && (cnt_r == HOLD_LIM);
		end
	endgenerate
endmodule : dlr_hold_timer

// file: hdl/dlr_group_sel.sv
// Decode of the group-activate inputs into an index and an error flag
`timescale 1ns/1ns
module dlr_group_sel #(
	parameter int NG = dlr_pkg::NUM_GROUPS,
	parameter int GW = dlr_pkg::GRP_W
) (
	input  wire logic [NG-1:0] group_act_in,
	input  wire logic [GW-1:0] default_group,
	output logic      [GW-1:0] group_idx,
	output logic               group_err
);
	// Index must address every group
	if (NG < 1 || NG > (2 ** GW)) begin : g_bad_groups
		$error("dlr_group_sel: group count does not fit the index");
	end

	// Lowest active input wins; none active keeps the fixed assignment
	always_comb begin
		logic seen;
		seen      = 1'h0;
		group_err = 1'h0;
		group_idx = default_group;
		for (int i = 0; i < NG; i++) begin
			if (group_act_in[i]) begin
				if (seen)
					group_err = 1'h1;
				else
					group_idx = GW'(i);
				seen = 1'h1;
			end
		end
	end
endmodule : dlr_group_sel

// file: hdl/dlr_close_release.sv
// Top of the dead-line close-release logic
`timescale 1ns/1ns
module dlr_close_release #(
	parameter int NG          = dlr_pkg::NUM_GROUPS,
	parameter int HOLD_CYCLES = dlr_pkg::HOLD_CYCLES
) (
	input  wire logic                                 clk_sys,
	input  wire logic                                 reset_n,
	// Request handshake with the switching control
	input  wire logic                                 meas_req_in,
	input  wire logic                                 req_from_reclose,
	output logic                                      measuring,
	output logic                                      close_permit,
	// Comparator flags from measurement
	input  wire logic [dlr_pkg::NUM_PHASES-1:0]       v1_live_ph,
	input  wire logic [dlr_pkg::NUM_PHASES-1:0]       v1_dead_ph,
	input  wire logic                                 v1_in_band,
	input  wire logic                                 v2_live,
	input  wire logic                                 v2_dead,
	input  wire logic                                 v2_in_band,
	input  wire logic                                 f1_in_range,
	input  wire logic                                 f2_in_range,
	input  wire logic                                 sync_ok,
	// External control inputs
	input  wire logic                                 ext_live_dead_in,
	input  wire logic                                 ext_dead_live_in,
	input  wire logic                                 ext_dead_dead_in,
	input  wire logic                                 ext_unchecked_release_in,
	input  wire logic                                 group_block_in,
	input  wire logic                                 close_permit_block_in,
	input  wire logic [NG-1:0]                        group_act_in,
	input  wire logic [dlr_pkg::GRP_W-1:0]            default_group,
	// Per-group settings
	input  wire logic [NG-1:0]                        cfg_group_on,
	input  wire logic [NG-1:0]                        cfg_three_phase,
	input  wire logic [NG-1:0]                        cfg_external,
	input  wire logic [NG-1:0]                        cfg_unchecked_release_enable,
	input  wire logic [NG-1:0][dlr_pkg::NUM_COND-1:0] cfg_dead_en_reclose,
	input  wire logic [NG-1:0][dlr_pkg::NUM_COND-1:0] cfg_dead_en_manual,
	input  wire logic [NG-1:0]                        cfg_sync_en_reclose,
	input  wire logic [NG-1:0]                        cfg_sync_en_manual,
	// Indications
	output logic                                      released_live_dead_ind,
	output logic                                      released_dead_live_ind,
	output logic                                      released_dead_dead_ind,
	output logic                                      blocked_ind,
	output logic                                      close_permit_blocked_ind,
	output logic                                      group_selection_error
);
	localparam int LD = dlr_pkg::COND_LD;
	localparam int DL = dlr_pkg::COND_DL;
	localparam int DD = dlr_pkg::COND_DD;

	// Group index width is set by the package; another group count cannot be served
	if (NG != dlr_pkg::NUM_GROUPS) begin : g_bad_groups
		$error("dlr_close_release: group count must match the package");
	end

	dlr_hold_if #(.NCOND(dlr_pkg::NUM_COND)) hif ();

	logic [dlr_pkg::GRP_W-1:0] grp;
	logic                      grp_err;

	dlr_group_sel #(
		.NG (NG),
		.GW (dlr_pkg::GRP_W)
	) u_group_sel (
		.group_act_in  (group_act_in),
		.default_group (default_group),
		.group_idx     (grp),
		.group_err     (grp_err)
	);

	dlr_hold_timer #(
		.NCOND       (dlr_pkg::NUM_COND),
		.CNT_W       (dlr_pkg::HOLD_CNT_W),
		.HOLD_CYCLES (HOLD_CYCLES)
	) u_hold_timer (
		.clk_sys (clk_sys),
		.reset_n (reset_n),
		.hif     (hif)
	);

	// Control state
	dlr_pkg::dlr_state_t state_r;
	dlr_pkg::dlr_state_t state_nxt;
	logic                rearm_r;
	logic                rearm_nxt;
	logic                src_ar_r;
	logic                src_ar_nxt;
	logic [dlr_pkg::GRP_W-1:0] grp_r;
	logic [dlr_pkg::GRP_W-1:0] grp_nxt;

	// Registered outputs
	logic                         permit_r;
	logic                         permit_nxt;
	logic [dlr_pkg::NUM_COND-1:0] rel_ind_r;
	logic [dlr_pkg::NUM_COND-1:0] rel_ind_nxt;
	logic                         blk_ind_r;
	logic                         blk_ind_nxt;
	logic                         cblk_ind_r;
	logic                         cblk_ind_nxt;
	logic                         gerr_r;
	logic                         gerr_nxt;

	// Settings of the active group
	logic                         s_three;
	logic                         s_ext;
	logic                         s_unchk;
	logic [dlr_pkg::NUM_COND-1:0] s_dead_en;
	logic                         s_sync_en;

	// Side classification and raw conditions
	logic                         v1_live;
	logic                         v1_dead;
	logic [dlr_pkg::NUM_COND-1:0] meas_cond;
	logic [dlr_pkg::NUM_COND-1:0] cond;
	logic                         meas;
	logic                         start_ok;

	// Settings follow the group latched at start; selection cannot jump mid-check
	always_comb begin
		s_three = cfg_three_phase[grp_r];
		s_ext   = cfg_external[grp_r];
		s_unchk = cfg_unchecked_release_enable[grp_r];
		if (src_ar_r) begin
			s_dead_en = cfg_dead_en_reclose[grp_r];
			s_sync_en = cfg_sync_en_reclose[grp_r];
		end else begin
			s_dead_en = cfg_dead_en_manual[grp_r];
			s_sync_en = cfg_sync_en_manual[grp_r];
		end
	end

	// Reference side: all phases on a three-phase connection; otherwise any phase for live, PHASE_SINGLE for dead
	always_comb begin
		if (s_three) begin
			v1_live = &v1_live_ph;
			v1_dead = &v1_dead_ph;
		end else begin
			v1_live = |v1_live_ph;
			v1_dead = v1_dead_ph[dlr_pkg::PHASE_SINGLE];
		end
	end

	// Flags are sampled every edge; no filtering beyond the hold timer
	always_comb begin
		meas_cond     = '0;
		meas_cond[LD] = v1_live && v1_in_band && v2_dead && f1_in_range;
		meas_cond[DL] = v1_dead && v2_live && v2_in_band && f2_in_range;
		meas_cond[DD] = v1_dead && v2_dead;
		if (s_ext)
			cond = {ext_dead_dead_in, ext_dead_live_in, ext_live_dead_in} & s_dead_en;
		else
			cond = meas_cond & s_dead_en;
	end

	assign meas       = (state_r == dlr_pkg::DLR_MEAS);
	assign hif.cond   = meas ? cond : '0;
	assign hif.clear  = !meas || group_block_in;
	assign start_ok   = meas_req_in && !rearm_r && !group_block_in && !grp_err
		&& cfg_group_on[grp];

	// Measurement sequence and request handling
	always_comb begin
		state_nxt  = state_r;
		rearm_nxt  = rearm_r;
		src_ar_nxt = src_ar_r;
		grp_nxt    = grp_r;
		if (!meas_req_in)
			rearm_nxt = 1'b0;
		unique case (state_r)
			dlr_pkg::DLR_IDLE: begin
				if (start_ok) begin
					state_nxt  = dlr_pkg::DLR_MEAS;
					src_ar_nxt = req_from_reclose;
					grp_nxt    = grp;
				end
			end
			dlr_pkg::DLR_MEAS: begin
				if (!meas_req_in)
					state_nxt = dlr_pkg::DLR_IDLE;
			end
		endcase
		// Block aborts everything and demands a new request edge
		if (group_block_in) begin
			state_nxt = dlr_pkg::DLR_IDLE;
			rearm_nxt = meas_req_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_r  <= dlr_pkg::DLR_IDLE;
			rearm_r  <= 1'b0;
			src_ar_r <= 1'b0;
			grp_r    <= '0;
		end else begin
			state_r  <= state_nxt;
			rearm_r  <= rearm_nxt;
			src_ar_r <= src_ar_nxt;
			grp_r    <= grp_nxt;
		end
	end

	// Release decision; close block masks only the output, not the check
	always_comb begin
		logic release_ok;
		release_ok   = 1'h0;
		permit_nxt   = 1'h0;
		rel_ind_nxt  = '0;
		cblk_ind_nxt = 1'h0;
		blk_ind_nxt  = group_block_in;
		gerr_nxt     = grp_err;
		if (meas && !group_block_in && meas_req_in) begin
			rel_ind_nxt  = hif.held;
			release_ok   = s_unchk
				|| ext_unchecked_release_in
				|| (|hif.held)
				|| (s_sync_en && sync_ok);
			permit_nxt   = release_ok && !close_permit_block_in;
			cblk_ind_nxt = close_permit_block_in;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			permit_r   <= 1'h0;
			rel_ind_r  <= '0;
			blk_ind_r  <= 1'h0;
			cblk_ind_r <= 1'h0;
			gerr_r     <= 1'h0;
		end else begin
			permit_r   <= permit_nxt;
			rel_ind_r  <= rel_ind_nxt;
			blk_ind_r  <= blk_ind_nxt;
			cblk_ind_r <= cblk_ind_nxt;
			gerr_r     <= gerr_nxt;
		end
	end

	// Measuring flag mirrors the state register directly
	assign measuring                = meas;
	assign close_permit             = permit_r;
	assign released_live_dead_ind   = rel_ind_r[LD];
	assign released_dead_live_ind   = rel_ind_r[DL];
	assign released_dead_dead_ind   = rel_ind_r[DD];
	assign blocked_ind              = blk_ind_r;
	assign close_permit_blocked_ind = cblk_ind_r;
	assign group_selection_error    = gerr_r;
endmodule : dlr_close_release

// file: dv/dlr_close_release_checker.sv
// Port-level temporal checks for the dead-line close-release logic
`timescale 1ns/1ns
module dlr_close_release_checker #(
	parameter int NG          = dlr_pkg::NUM_GROUPS,
	parameter int HOLD_CYCLES = dlr_pkg::HOLD_CYCLES
) (
	input wire logic          clk_sys,
	input wire logic          reset_n,
	input wire logic          meas_req_in,
	input wire logic          measuring,
	input wire logic          close_permit,
	input wire logic          ext_unchecked_release_in,
	input wire logic          group_block_in,
	input wire logic          close_permit_block_in,
	input wire logic [NG-1:0] group_act_in,
	input wire logic          released_live_dead_ind,
	input wire logic          released_dead_live_ind,
	input wire logic          released_dead_dead_ind,
	input wire logic          blocked_ind,
	input wire logic          close_permit_blocked_ind,
	input wire logic          group_selection_error
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);

	// Consecutive measuring cycles; a counter, since a deep past would not scale with the hold
	int meas_run_r;
	always_ff @(posedge clk_sys) begin
		if (!reset_n || !measuring)
			meas_run_r <= 0;
		else if (meas_run_r <= HOLD_CYCLES)
			meas_run_r <= meas_run_r + 1;
	end

	// Full block raises its indication and ends the check and the permit on the next edge
	AST_BLOCK: assert property (group_block_in |=> blocked_ind && !measuring && !close_permit)
		else $error("block did not reset the check");
	AST_CLOSE_BLK: assert property (close_permit_block_in |=> !close_permit)
		else $error("close permit passed while blocked");
	AST_CLOSE_IND: assert property (
		measuring && meas_req_in && !group_block_in && close_permit_block_in
		|=> close_permit_blocked_ind)
		else $error("close block not indicated");
	AST_GRP_ERR: assert property ($countones(group_act_in) > 1 |=> group_selection_error)
		else $error("double group selection not flagged");
	AST_WITHDRAW: assert property (!meas_req_in |=> !measuring && !close_permit)
		else $error("check kept running after withdrawal");
	AST_PERMIT_MEAS: assert property (close_permit |-> $past(measuring))
		else $error("permit without a running check");
	// Indication may only rise after a full hold spent measuring
	AST_HOLD: assert property (
		$rose(|{released_live_dead_ind, released_dead_live_ind, released_dead_dead_ind})
		|-> meas_run_r > HOLD_CYCLES)
		else $error("dead-side release before hold time");
	AST_UNCHECKED: assert property (
		measuring && meas_req_in && ext_unchecked_release_in && !close_permit_block_in
		&& !group_block_in |=> close_permit)
		else $error("direct release not granted");

	COV_DEAD: cover property (close_permit && released_dead_live_ind);
	COV_BLOCK: cover property (blocked_ind);
	COV_CLOSE_BLK: cover property (close_permit_blocked_ind && measuring);
endmodule : dlr_close_release_checker

bind dlr_close_release dlr_close_release_checker #(.NG(NG), .HOLD_CYCLES(HOLD_CYCLES)) u_chk (
	.clk_sys, .reset_n, .meas_req_in, .measuring, .close_permit, .ext_unchecked_release_in,
	.group_block_in, .close_permit_block_in, .group_act_in, .released_live_dead_ind,
	.released_dead_live_ind, .released_dead_dead_ind, .blocked_ind, .close_permit_blocked_ind,
	.group_selection_error
);

// file: dv/dlr_sw_ctrl_model.sv
// Switching-control model: close requests and their conclusion
`timescale 1ns/1ns
module dlr_sw_ctrl_model (
	input  wire logic        clk_sys,
	input  wire logic        cmd,
	input  wire logic        reclose,
	input  wire logic [15:0] limit,
	input  wire logic        close_permit,
	output logic             meas_req_in,
	output logic             req_from_reclose,
	output logic             done,
	output logic             ok
);
	logic [15:0] wait_r = 16'h0000;
	initial {meas_req_in, req_from_reclose, done, ok} = 4'h0;
	// Request held as a level; long limit models a patient control
	always @(posedge clk_sys) begin
		done <= 1'h0;
		if (cmd && !meas_req_in) begin
			meas_req_in      <= 1'h1;
			req_from_reclose <= reclose;
			wait_r           <= limit;
		end else if (meas_req_in) begin
			wait_r <= wait_r - 16'h0001;
			if (close_permit || wait_r == 16'h0000) begin
				meas_req_in <= 1'h0;
				ok          <= close_permit;
				done        <= 1'h1;
			end
		end
	end
endmodule : dlr_sw_ctrl_model

// file: dv/test_dead_line_close_release_logic.sv
// Self-checking bench for the dead-line close-release logic
`timescale 1ns/1ns
module test_dead_line_close_release_logic;
	localparam int HOLD = 5;
	logic        clk_sys, reset_n, meas_req_in, req_from_reclose, measuring, close_permit;
	logic [2:0]  v1_live_ph, v1_dead_ph;
	logic        v1_in_band, v2_live, v2_dead, v2_in_band, f1_in_range, f2_in_range, sync_ok;
	logic        ext_live_dead_in, ext_dead_live_in, ext_dead_dead_in, ext_unchecked_release_in;
	logic        group_block_in, close_permit_block_in, cmd, reclose, done, ok;
	logic [3:0]  group_act_in, cfg_group_on, cfg_three_phase, cfg_external;
	logic [3:0]  cfg_unchecked_release_enable, cfg_sync_en_reclose, cfg_sync_en_manual;
	logic [1:0]  default_group;
	logic [3:0][2:0] cfg_dead_en_reclose, cfg_dead_en_manual;
	logic        released_live_dead_ind, released_dead_live_ind, released_dead_dead_ind;
	logic        blocked_ind, close_permit_blocked_ind, group_selection_error;
	logic [15:0] limit;
	logic [3:0]  exp_q[$];
	int          errors, checked, g;

	// Device with a short supervision hold, and its switching control
	dlr_close_release #(.HOLD_CYCLES(HOLD)) dut (
		.clk_sys, .reset_n, .meas_req_in, .req_from_reclose, .measuring, .close_permit,
		.v1_live_ph, .v1_dead_ph, .v1_in_band, .v2_live, .v2_dead, .v2_in_band,
		.f1_in_range, .f2_in_range, .sync_ok, .ext_live_dead_in, .ext_dead_live_in,
		.ext_dead_dead_in, .ext_unchecked_release_in, .group_block_in,
		.close_permit_block_in, .group_act_in, .default_group, .cfg_group_on,
		.cfg_three_phase, .cfg_external, .cfg_unchecked_release_enable,
		.cfg_dead_en_reclose, .cfg_dead_en_manual, .cfg_sync_en_reclose, .cfg_sync_en_manual,
		.released_live_dead_ind, .released_dead_live_ind, .released_dead_dead_ind,
		.blocked_ind, .close_permit_blocked_ind, .group_selection_error
	);
	dlr_sw_ctrl_model ctrl (.clk_sys, .cmd, .reclose, .limit, .close_permit, .meas_req_in,
		.req_from_reclose, .done, .ok);

	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic check(input logic [3:0] seen, input logic [3:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic tally_and_finish;
		// A note never matched by a concluded request is a miss
		if (exp_q.size() > 0)
			errors++;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish

	// Note the expected outcome, issue one close command, wait bounded
	task automatic run(input logic exp_ok, input logic [2:0] exp_ind, input logic src);
		int n;
		exp_q.push_back({exp_ok, exp_ind});
		@(posedge clk_sys);
		cmd     <= 1'h1;
		reclose <= src;
		@(posedge clk_sys);
		cmd <= 1'h0;
		n = 0;
		while (done !== 1'h1 && n < 300) begin
			@(posedge clk_sys);
			n++;
		end
		if (n >= 300) check(done, 4'h1);
		repeat (3) @(posedge clk_sys);
	endtask : run

	// Comparator flags for one dead-side case; 3 means no case holds
	task automatic set_flags(input int c);
		v1_live_ph <= (c == 0) ? 3'h7 : 3'h0;
		v1_dead_ph <= (c == 1 || c == 2) ? 3'h7 : 3'h0;
		v2_live    <= (c == 1);
		v2_dead    <= (c == 0 || c == 2);
		v1_in_band <= (c == 0);
		v2_in_band <= (c == 1);
	endtask : set_flags

	// Scoreboard: oldest note against each concluded request
	always @(negedge clk_sys) begin
		if (done === 1'h1 && exp_q.size() > 0)
			check({ok, released_dead_dead_ind, released_dead_live_ind, released_live_dead_ind},
				exp_q.pop_front());
	end

	// Hang guard, well past the expected run length
	initial begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		tally_and_finish();
	end

	initial begin
		{v1_live_ph, v1_dead_ph, v1_in_band, v2_live, v2_dead, v2_in_band, sync_ok} = '0;
		{ext_live_dead_in, ext_dead_live_in, ext_dead_dead_in, ext_unchecked_release_in} = '0;
		{group_block_in, close_permit_block_in, cmd, reclose, reset_n} = '0;
		{group_act_in, default_group, cfg_external, cfg_unchecked_release_enable} = '0;
		{cfg_dead_en_reclose, cfg_dead_en_manual, cfg_sync_en_reclose, cfg_sync_en_manual} = '0;
		{f1_in_range, f2_in_range} = 2'h3;
		cfg_group_on    = 4'h1;
		cfg_three_phase = 4'hf;
		limit           = 16'h001e;
		void'($urandom(4));
		repeat (16) @(posedge clk_sys);
		reset_n <= 1'h1;
		@(negedge clk_sys);
		check({measuring, close_permit, blocked_ind, group_selection_error}, 4'h0);
		// Each dead-side case through the matching and the other enable set
		for (int c = 0; c < 3; c++) begin
			for (int s = 0; s < 2; s++) begin
				set_flags(c);
				cfg_dead_en_reclose[0] <= s ? (3'h1 << c) : 3'h0;
				cfg_dead_en_manual[0]  <= s ? 3'h0 : (3'h1 << c);
				run(1'h1, 3'h1 << c, s[0]);
				run(1'h0, 3'h0, !s[0]);
			end
		end
		$display("dead-side cases done");
		set_flags(0);
		cfg_dead_en_reclose[0] <= 3'h0;
		cfg_dead_en_manual[0]  <= 3'h1;
		cfg_three_phase        <= 4'h0;
		@(posedge clk_sys);
		v1_live_ph <= 3'h4;
		run(1'h1, 3'h1, 1'h0);
		cfg_three_phase <= 4'hf;
		run(1'h0, 3'h0, 1'h0);
		$display("phase connection done");
		set_flags(3);
		cfg_dead_en_manual[0] <= 3'h0;
		sync_ok               <= 1'h1;
		cfg_sync_en_reclose   <= 4'h1;
		run(1'h1, 3'h0, 1'h1);
		run(1'h0, 3'h0, 1'h0);
		$display("synchronous enable done");
		sync_ok               <= 1'h0;
		cfg_external          <= 4'h1;
		ext_dead_dead_in      <= 1'h1;
		ext_live_dead_in      <= 1'h1;
		cfg_dead_en_manual[0] <= 3'h4;
		run(1'h1, 3'h4, 1'h0);
		$display("external conditions done");
		{cfg_external, ext_dead_dead_in, ext_live_dead_in} <= '0;
		cfg_dead_en_manual[0]        <= 3'h0;
		cfg_unchecked_release_enable <= 4'h1;
		run(1'h1, 3'h0, 1'h0);
		cfg_unchecked_release_enable <= 4'h0;
		ext_unchecked_release_in     <= 1'h1;
		run(1'h1, 3'h0, 1'h0);
		$display("unchecked release done");
		close_permit_block_in <= 1'h1;
		limit                 <= 16'h003c;
		fork
			run(1'h1, 3'h0, 1'h0);
			begin
				repeat (10) @(negedge clk_sys);
				check({measuring, close_permit, close_permit_blocked_ind}, 4'h5);
				@(posedge clk_sys);
				close_permit_block_in <= 1'h0;
			end
		join
		$display("close block done");
		ext_unchecked_release_in <= 1'h0;
		fork
			run(1'h0, 3'h0, 1'h0);
			begin
				repeat (6) @(posedge clk_sys);
				group_block_in <= 1'h1;
				@(posedge clk_sys);
				group_block_in <= 1'h0;
				@(negedge clk_sys);
				check({measuring, blocked_ind}, 4'h1);
				repeat (8) @(negedge clk_sys);
				check(measuring, 4'h0);
			end
		join
		$display("group block done");
		g = $urandom_range(3, 0);
		cfg_group_on                 <= 4'h1 << g;
		cfg_unchecked_release_enable <= 4'h1 << g;
		group_act_in                 <= 4'h1 << g;
		run(1'h1, 3'h0, 1'h0);
		group_act_in <= 4'h1 << ((g + 1) % 4);
		run(1'h0, 3'h0, 1'h0);
		group_act_in <= (4'h1 << g) | (4'h1 << ((g + 1) % 4));
		run(1'h0, 3'h0, 1'h0);
		@(negedge clk_sys);
		check(group_selection_error, 4'h1);
		$display("group selection done");
		tally_and_finish();
	end
endmodule : test_dead_line_close_release_logic
